/* hw/rrd_consts.svh */
// Offsets, field positions, reset values and timing counts of the reset-domain register bank
`ifndef RRD_CONSTS_SVH
`define RRD_CONSTS_SVH

`define RRD_AW 8
`define RRD_DW 8
`define RRD_OFF_SELF_TEST 8'h00
`define RRD_OFF_TEST_LEN 8'h04
`define RRD_OFF_STATUS 8'h08
`define RRD_OFF_FAULT 8'h0c
`define RRD_BIT_CAPABLE 7
`define RRD_BIT_START 6
`define RRD_CODE_MSB 3
`define RRD_CODE_LSB 0
`define RRD_BIT_LOCKED 0
`define RRD_BIT_RUNNING 1
`define RRD_BIT_INJECT 0
`define RRD_RST_CODE 4'h0
`define RRD_RST_TEST_LEN 8'h10
`define RRD_CODE_PASS 4'h0
`define RRD_CODE_MISMATCH 4'h1
`define RRD_LFSR_SEED 8'ha5
`define RRD_SYNC_STAGES 2

`endif

/* hw/rrd_pkg.sv */
// Types shared by the reset-domain register bank
package rrd_pkg;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } rrd_bus_req_t;

  typedef enum logic [1:0] {
    RRD_IDLE = 2'b00,
    RRD_RUN = 2'b01
  } rrd_state_t;

endpackage : rrd_pkg

/* hw/rrd_reset_sync.sv */
// Reset synchroniser: asserts at once, releases on the clock
module rrd_reset_sync (
  // Clock and raw reset
  input wire logic clk,
  input wire logic raw_rst_n,
  // Synchronised reset
  output logic sync_rst_n
);

  logic [1:0] stage_q;

  // Release passes two flops so no field sees a metastable edge
  always_ff @(posedge clk or negedge raw_rst_n) begin
    if (!raw_rst_n) begin
      stage_q <= 2'b00;
    end else begin
      stage_q <= {stage_q[0], 1'b1};
    end
  end

  assign sync_rst_n = stage_q[1];

endmodule : rrd_reset_sync

/* hw/rrd_top.sv */
// Register bank with hard and soft reset domains and a self-test register
`include "rrd_consts.svh"

////////////////////////////////////////////////////////////////////////////////
// Behaviour
// - Fields default to the soft field reset
// - Only one signal is the field reset
// - Hard reset resets the host port logic
// - Without host reset, one signal resets all
// - Only one signal is the host reset
// - Nested scope inherits the host reset
// - Selected reset loads each field's reset value
// - Reset re-arms write-once fields
// - Reset source chosen by fixed priority
// - Reset polarity and timing follow the signal
// - Signal resets only fields referencing it
// - Hard OR soft forms master; sticky survives soft
// - Bits 3:0 hold result, zero is pass
// - Software sets start; device clears on completion
// - Capable bit shows support, hard reset only
// - Unsupported device reads register as zero
// - Running test never blocks the host bus
module rrd_top
  import rrd_pkg::*;
#(
  // Whether the self test is built in
  parameter bit CAP_SUPPORTED = 1'b1
) (
  // Clock and resets
  input wire logic SYS_CLK,
  input wire logic NRST,
  input wire logic SOFT_RST_N,
  // Register port
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  // Status
  output logic SELF_TEST_BUSY
);

  ////////////////////////////////////////////////////////////////////////////////
  // Reset domains

  logic [1:0] raw_rst_n;
  logic [1:0] sync_rst_n;
  logic hrst_n;
  logic mrst_n;

  assign raw_rst_n = {NRST & SOFT_RST_N, NRST};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_rst
      rrd_reset_sync u_sync (
        .clk(SYS_CLK),
        .raw_rst_n(raw_rst_n[gi]),
        .sync_rst_n(sync_rst_n[gi])
      );
    end
  endgenerate

  assign hrst_n = sync_rst_n[0];
  assign mrst_n = sync_rst_n[1];

  ////////////////////////////////////////////////////////////////////////////////
  // Bus request

  rrd_bus_req_t req;

  assign req = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  logic wr_st;
  logic wr_len;
  logic wr_fault;

  assign wr_st = req.wr && hit(req.addr, `RRD_OFF_SELF_TEST);
  assign wr_len = req.wr && hit(req.addr, `RRD_OFF_TEST_LEN);
  assign wr_fault = req.wr && hit(req.addr, `RRD_OFF_FAULT);

  ////////////////////////////////////////////////////////////////////////////////
  // Fields

  rrd_state_t state_q;
  logic start_q;
  logic [3:0] code_q;
  logic capable_q;
  logic [7:0] len_q;
  logic locked_q;
  logic inject_q;
  logic [7:0] cnt_q;
  logic [7:0] lfsr_a_q;
  logic [7:0] lfsr_b_q;
  logic mismatch_q;
  logic launch;
  logic finish;

  assign launch = wr_st && req.wdata[`RRD_BIT_START] && capable_q && (state_q == RRD_IDLE);
  assign finish = (state_q == RRD_RUN) && (cnt_q == 8'h01);

  always_ff @(posedge SYS_CLK or negedge hrst_n) begin
    if (!hrst_n) begin
      capable_q <= 1'b0;
    end else begin
      capable_q <= CAP_SUPPORTED;
    end
  end

  always_ff @(posedge SYS_CLK or negedge mrst_n) begin
    if (!mrst_n) begin
      start_q <= 1'b0;
    end else if (finish) begin
      start_q <= 1'b0;
    end else if (launch) begin
      start_q <= 1'b1;
    end
  end

  always_ff @(posedge SYS_CLK or negedge mrst_n) begin
    if (!mrst_n) begin
      code_q <= `RRD_RST_CODE;
    end else if (finish) begin
      code_q <= (mismatch_q || (lfsr_a_q != lfsr_b_q)) ? `RRD_CODE_MISMATCH : `RRD_CODE_PASS;
    end else if (launch) begin
      code_q <= `RRD_CODE_PASS;
    end
  end

  always_ff @(posedge SYS_CLK or negedge mrst_n) begin
    if (!mrst_n) begin
      len_q <= `RRD_RST_TEST_LEN;
      locked_q <= 1'b0;
    end else if (wr_len && !locked_q) begin
      len_q <= req.wdata;
      locked_q <= 1'b1;
    end
  end

  always_ff @(posedge SYS_CLK or negedge mrst_n) begin
    if (!mrst_n) begin
      inject_q <= 1'b0;
    end else if (wr_fault) begin
      inject_q <= req.wdata[`RRD_BIT_INJECT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Self-test engine: two LFSR copies must agree for the whole run

  function automatic logic [7:0] lfsr_next(input logic [7:0] v);
    lfsr_next = {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction : lfsr_next

  always_ff @(posedge SYS_CLK or negedge mrst_n) begin
    if (!mrst_n) begin
      state_q <= RRD_IDLE;
      cnt_q <= 8'h00;
    end else begin
      unique case (state_q)
        RRD_IDLE: begin
          if (launch) begin
            state_q <= RRD_RUN;
            cnt_q <= (len_q == 8'h00) ? 8'h01 : len_q;
          end
        end
        RRD_RUN: begin
          cnt_q <= cnt_q - 8'h01;
          if (finish) begin
            state_q <= RRD_IDLE;
          end
        end
        default: begin
          state_q <= RRD_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge SYS_CLK or negedge mrst_n) begin
    if (!mrst_n) begin
      lfsr_a_q <= `RRD_LFSR_SEED;
      lfsr_b_q <= `RRD_LFSR_SEED;
      mismatch_q <= 1'b0;
    end else if (launch) begin
      lfsr_a_q <= `RRD_LFSR_SEED;
      lfsr_b_q <= `RRD_LFSR_SEED;
      mismatch_q <= 1'b0;
    end else if (state_q == RRD_RUN) begin
      lfsr_a_q <= lfsr_next(lfsr_a_q);
      lfsr_b_q <= lfsr_next(lfsr_b_q) ^ {7'h00, inject_q};
      mismatch_q <= mismatch_q | (lfsr_a_q != lfsr_b_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Host port: reset by hard reset only, so soft reset never disturbs a read

  logic [7:0] st_val;
  logic [7:0] rd_val;

  assign st_val = CAP_SUPPORTED ? {capable_q, start_q, 2'b00, code_q} : 8'h00;

  always_comb begin
    rd_val = 8'h00;
    if (hit(req.addr, `RRD_OFF_SELF_TEST)) begin
      rd_val = st_val;
    end else if (hit(req.addr, `RRD_OFF_TEST_LEN)) begin
      rd_val = len_q;
    end else if (hit(req.addr, `RRD_OFF_STATUS)) begin
      rd_val = {6'h00, state_q == RRD_RUN, locked_q};
    end else if (hit(req.addr, `RRD_OFF_FAULT)) begin
      rd_val = {7'h00, inject_q};
    end
  end

  always_ff @(posedge SYS_CLK or negedge hrst_n) begin
    if (!hrst_n) begin
      RDATA <= 8'h00;
    end else begin
      RDATA <= req.rd ? rd_val : 8'h00;
    end
  end

  // Soft reset touches only its fields
  always_ff @(posedge SYS_CLK or negedge hrst_n) begin
    if (!hrst_n) begin
      SELF_TEST_BUSY <= 1'b0;
    end else begin
      SELF_TEST_BUSY <= (state_q == RRD_RUN) && !finish || launch;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!hrst_n);

  property p_start_clears;
    finish |=> !start_q && (state_q == RRD_IDLE);
  endproperty
  a_start_clears: assert property (p_start_clears)
    else $error("start bit not cleared at completion");

  property p_run_len;
    launch && (len_q > 8'h01) |=> start_q && (cnt_q == $past(len_q));
  endproperty
  a_run_len: assert property (p_run_len)
    else $error("test length not loaded on launch");

  property p_pass_code;
    finish && !mismatch_q && (lfsr_a_q == lfsr_b_q) |=> code_q == `RRD_CODE_PASS;
  endproperty
  a_pass_code: assert property (p_pass_code)
    else $error("passing test gave nonzero code");

  property p_fail_code;
    finish && mismatch_q |=> code_q == `RRD_CODE_MISMATCH;
  endproperty
  a_fail_code: assert property (p_fail_code)
    else $error("failing test gave pass code");

  property p_wonce;
    locked_q && wr_len && mrst_n |=> $stable(len_q);
  endproperty
  a_wonce: assert property (p_wonce)
    else $error("write-once field changed twice");

  property p_field_rst;
    !mrst_n |-> !start_q && !locked_q && (code_q == `RRD_RST_CODE);
  endproperty
  a_field_rst: assert property (p_field_rst)
    else $error("field reset did not load reset value");

  property p_cap_sticky;
    $past(hrst_n) |-> capable_q == CAP_SUPPORTED;
  endproperty
  a_cap_sticky: assert property (p_cap_sticky)
    else $error("capable bit lost outside hard reset");

  property p_unsup_zero;
    req.rd && hit(req.addr, `RRD_OFF_SELF_TEST) && !CAP_SUPPORTED |=> RDATA == 8'h00;
  endproperty
  a_unsup_zero: assert property (p_unsup_zero)
    else $error("unsupported device read nonzero");

  property p_read_busy;
    req.rd && hit(req.addr, `RRD_OFF_STATUS) && (state_q == RRD_RUN) |=> RDATA[1];
  endproperty
  a_read_busy: assert property (p_read_busy)
    else $error("read during test not served");

  property p_rd_idle;
    !req.rd |=> RDATA == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data outside its cycle");

  c_pass: cover property (finish && !mismatch_q);
  c_fail: cover property (finish && inject_q);
  c_soft_mid_run: cover property ((state_q == RRD_RUN) ##1 !mrst_n);
  c_rearm: cover property (locked_q ##1 !mrst_n ##[1:4] wr_len);

endmodule : rrd_top

/* testbench/rrd_host.sv */
// Host bus model that issues register reads and writes
`include "rrd_consts.svh"
module rrd_host (
  // Clock
  input wire logic clk,
  // Register port
  output logic [7:0] addr,
  output logic [7:0] wdata,
  output logic wr,
  output logic rd,
  input wire logic [7:0] rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    addr = 8'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
  end
  // Released lines show the inverse so a stale value never looks valid
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    addr <= ~a;
    wdata <= ~d;
  endtask : write_reg
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    addr <= ~a;
    // Sample mid-cycle, well clear of the edges that launch and drop the data
    @(negedge clk);
    d = rdata;
  endtask : read_reg
  // bounded start poll
  // A bound of 200 polls stands in for the host's long wall-clock limit
  task automatic wait_start_clear(output logic ok);
    logic [7:0] d;
    ok = 1'b0;
    for (int i = 0; i < 200 && !ok; i++) begin
      read_reg(`RRD_OFF_SELF_TEST, d);
      ok = (d[`RRD_BIT_START] === 1'b0);
    end
  endtask : wait_start_clear
endmodule : rrd_host

/* testbench/tb.sv */
// Self-checking bench for the reset-domain register bank
`include "rrd_consts.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic soft_rst_n = 1'b1;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  logic [7:0] rdata;
  logic [7:0] rdata_nocap;
  logic busy;
  logic [7:0] v;
  logic ok;
  int num_errors = 0;
  int comparisons = 0;
  int cycles = 0;
  always #50 sys_clk = ~sys_clk;
  rrd_host host_u (.clk(sys_clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
  rrd_top dut_u (.SYS_CLK(sys_clk), .NRST(nrst), .SOFT_RST_N(soft_rst_n), .ADDR(addr),
    .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .SELF_TEST_BUSY(busy));
  rrd_top #(.CAP_SUPPORTED(1'b0)) nocap_u (.SYS_CLK(sys_clk), .NRST(nrst),
    .SOFT_RST_N(soft_rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata_nocap), .SELF_TEST_BUSY());
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic conclude();
    $display("comparisons=%0d num_errors=%0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : conclude
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset_vals();
    host_u.write_reg(`RRD_OFF_SELF_TEST, 8'h0f);
    host_u.read_reg(`RRD_OFF_SELF_TEST, v);
    chk(v, 8'h80);
    chk(rdata_nocap, 8'h00);
    host_u.read_reg(`RRD_OFF_TEST_LEN, v);
    chk(v, `RRD_RST_TEST_LEN);
    host_u.read_reg(8'h10, v);
    chk(v, 8'h00);
    $display("t_reset_vals done");
  endtask : t_reset_vals
  task automatic t_run();
    host_u.write_reg(`RRD_OFF_TEST_LEN, 8'h20);
    host_u.write_reg(`RRD_OFF_TEST_LEN, 8'h07);
    host_u.read_reg(`RRD_OFF_TEST_LEN, v);
    chk(v, 8'h20);
    host_u.write_reg(`RRD_OFF_SELF_TEST, 8'h40);
    host_u.read_reg(`RRD_OFF_SELF_TEST, v);
    chk(v, 8'hc0);
    chk(rdata_nocap, 8'h00);
    chk({7'h00, busy}, 8'h01);
    host_u.read_reg(`RRD_OFF_STATUS, v);
    chk(v, 8'h03);
    host_u.wait_start_clear(ok);
    chk({7'h00, ok}, 8'h01);
    host_u.read_reg(`RRD_OFF_SELF_TEST, v);
    chk(v, 8'h80);
    $display("t_run done");
  endtask : t_run
  task automatic t_fault();
    host_u.write_reg(`RRD_OFF_FAULT, 8'h01);
    host_u.write_reg(`RRD_OFF_SELF_TEST, 8'h40);
    host_u.wait_start_clear(ok);
    host_u.read_reg(`RRD_OFF_SELF_TEST, v);
    chk(v, 8'h81);
    host_u.write_reg(`RRD_OFF_FAULT, 8'h00);
    $display("t_fault done");
  endtask : t_fault
  task automatic t_soft();
    host_u.write_reg(`RRD_OFF_SELF_TEST, 8'h40);
    #10;
    chk({7'h00, busy}, 8'h01);
    @(posedge sys_clk);
    soft_rst_n <= 1'b0;
    // Busy is a host-side flop, so it drops one edge after the run is reset
    @(posedge sys_clk);
    #10;
    chk({7'h00, busy}, 8'h00);
    @(posedge sys_clk);
    soft_rst_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    host_u.read_reg(`RRD_OFF_SELF_TEST, v);
    chk(v, 8'h80);
    host_u.read_reg(`RRD_OFF_TEST_LEN, v);
    chk(v, `RRD_RST_TEST_LEN);
    host_u.write_reg(`RRD_OFF_TEST_LEN, 8'h05);
    host_u.read_reg(`RRD_OFF_TEST_LEN, v);
    chk(v, 8'h05);
    $display("t_soft done");
  endtask : t_soft
  task automatic t_hard();
    host_u.write_reg(`RRD_OFF_SELF_TEST, 8'h40);
    host_u.write_reg(`RRD_OFF_FAULT, 8'h01);
    #10;
    chk({7'h00, busy}, 8'h01);
    @(posedge sys_clk);
    nrst <= 1'b0;
    #10;
    chk({7'h00, busy}, 8'h00);
    chk(rdata, 8'h00);
    repeat (5) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (4) @(posedge sys_clk);
    host_u.read_reg(`RRD_OFF_TEST_LEN, v);
    chk(v, `RRD_RST_TEST_LEN);
    host_u.read_reg(`RRD_OFF_FAULT, v);
    chk(v, 8'h00);
    $display("t_hard done");
  endtask : t_hard
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      num_errors++;
      conclude();
    end
  end
  initial begin
    repeat (5) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (4) @(posedge sys_clk);
    t_reset_vals();
    t_run();
    t_fault();
    t_soft();
    t_hard();
    conclude();
  end
endmodule : tb
